// ### src/adcctl_clk_if.sv
// carrier between the control logic and its prescaler
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none

interface adcctl_clk_if;
	logic run;
	logic [2:0] divider;
	logic tick;
	modport ctrl (output run, output divider, input tick);
	modport div (input run, input divider, output tick);
endinterface

`default_nettype wire

// ### src/adcctl_params.svh
// constants for the converter control block: offsets, fields, counts
// assumes an 8-bit register port and a 10-bit converter core
`ifndef ADCCTL_PARAMS_SVH
`define ADCCTL_PARAMS_SVH

// register offsets on the plain register port
`define ADC_OFS_RES_LO 8'h78
`define ADC_OFS_RES_HI 8'h79
`define ADC_OFS_CSA 8'h7a
`define ADC_OFS_TRIG 8'h7b
`define ADC_OFS_CHSEL 8'h7c

// control_status_a fields
`define CSA_EN 7
`define CSA_START 6
`define CSA_AUTO 5
`define CSA_FLAG 4
`define CSA_IE 3
`define CSA_DIV_HI 2
`define CSA_DIV_LO 0

// channel_select fields
`define CHSEL_REF_HI 7
`define CHSEL_REF_LO 6
`define CHSEL_LEFT 5
`define CHSEL_CHAN_HI 4
`define CHSEL_CHAN_LO 0

// trigger source field
`define TRIG_SEL_HI 2
`define TRIG_SEL_LO 0
`define TRIG_FREE 3'h0

// reset values
`define CSA_RESET 8'h00
`define CHSEL_RESET 8'h00
`define TRIG_RESET 3'h0

// converter clocks per conversion
`define CONV_FIRST_CLKS 5'd25
`define CONV_NORMAL_CLKS 5'd13

// channel codes and result limits
`define RESULT_WIDTH 10
`define CHAN_DIFF_FIRST 5'h10
`define CHAN_BANDGAP 5'h1e
`define DIFF_MAX 10'h1ff

// prescaler
`define DIV_CNT_WIDTH 7
`define DIV_MIN_SHIFT 3'h1

`endif

// ### src/adcctl_pkg.sv
// types shared by the converter control modules
// assumes the constants header is on the include path
`include "adcctl_params.svh"

package adcctl_pkg;

	typedef enum logic [1:0] {
		adcctl_idle = 2'b00,
		adcctl_conv = 2'b01
	} adcctl_fsm_t;

	typedef struct packed {
		adcctl_fsm_t fsm;
		logic enable;
		logic busy;
		logic auto_trigger_enable;
		logic conversion_done_flag;
		logic conversion_done_irq_enable;
		logic [2:0] converter_clock_divider;
		logic [1:0] reference_select;
		logic left_align_result;
		logic [4:0] input_channel_select;
		logic [1:0] active_reference;
		logic [4:0] active_channel;
		logic [2:0] trigger_source_select;
		logic [`RESULT_WIDTH-1:0] result;
		logic locked;
		logic initialized;
		logic [4:0] count;
		logic trig_prev;
		logic [7:0] rdata;
		logic irq_request;
		logic core_start;
		logic core_step;
	} adcctl_state_t;

	typedef struct packed {
		logic [`DIV_CNT_WIDTH-1:0] count;
		logic tick;
	} adcctl_div_state_t;

endpackage

// ### src/adcctl_prescaler.sv
// converter clock prescaler: one-cycle tick every divided period
// assumes run and divider are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_params.svh"

module adcctl_prescaler (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// control side
	adcctl_clk_if.div clk_if
);

	adcctl_pkg::adcctl_div_state_t s;
	adcctl_pkg::adcctl_div_state_t next_s;
	logic [2:0] shift;
	logic [`DIV_CNT_WIDTH-1:0] terminal;

	always_comb begin
		next_s = s;
		// codes 0 and 1 both divide by two
		shift = (clk_if.divider < `DIV_MIN_SHIFT) ? `DIV_MIN_SHIFT : clk_if.divider;
		terminal = `DIV_CNT_WIDTH'((8'h01 << shift) - 8'h01);
		next_s.tick = 1'b0;
		if (!clk_if.run) begin
			next_s.count = '0;
		end else if (s.count >= terminal) begin
			next_s.count = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.count = s.count + `DIV_CNT_WIDTH'(1);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign clk_if.tick = s.tick;

endmodule

`default_nettype wire

// ### src/adcctl_top.sv
// converter control: registers, conversion sequencing, result format
// assumes an analog core that samples on core_start and holds its
// 10-bit answer valid on core_result by the final converter clock
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_params.svh"

module adcctl_top (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// processor interrupt side
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	output logic irq_request,
	// auto trigger sources, bit 0 unused
	input wire logic [7:0] trigger_sources,
	// analog core
	output logic core_power,
	output logic core_start,
	output logic core_step,
	output logic [1:0] core_reference,
	output logic [4:0] core_channel,
	input wire logic [`RESULT_WIDTH-1:0] core_result,
	input wire logic core_overrange
);

	adcctl_pkg::adcctl_state_t s;
	adcctl_pkg::adcctl_state_t next_s;
	adcctl_clk_if clk_if ();

	logic trig_level;
	logic trig_edge;
	logic fin;
	logic start_req;
	logic clr_flag;
	logic diff;
	logic [4:0] last;
	logic [`RESULT_WIDTH-1:0] captured;
	logic [7:0] res_lo;
	logic [7:0] res_hi;

	adcctl_prescaler u_prescaler (
		.mclk(mclk),
		.reset_n(reset_n),
		.clk_if(clk_if)
	);

	// prescaler only runs while the converter is powered
	assign clk_if.run = s.enable;
	assign clk_if.divider = s.converter_clock_divider;

	always_comb begin
		next_s = s;
		next_s.core_start = 1'b0;
		next_s.rdata = 8'h00;
		start_req = 1'b0;
		clr_flag = 1'b0;
		fin = 1'b0;

		// edge on the selected source; free-running selects a quiet zero
		trig_level = (s.trigger_source_select == `TRIG_FREE) ? 1'b0 :
			trigger_sources[s.trigger_source_select];
		trig_edge = trig_level & ~s.trig_prev;
		next_s.trig_prev = trig_level;

		// differential codes lie between the pairs start and the bandgap
		diff = (s.active_channel >= `CHAN_DIFF_FIRST) &&
			(s.active_channel < `CHAN_BANDGAP);
		// core answers in two's complement for pairs, straight binary otherwise
		captured = (diff && core_overrange) ? `DIFF_MAX : core_result;

		// result byte placement follows the live alignment bit
		if (s.left_align_result) begin
			res_hi = s.result[9:2];
			res_lo = {s.result[1:0], 6'h00};
		end else begin
			res_hi = {6'h00, s.result[9:8]};
			res_lo = s.result[7:0];
		end

		// register writes
		if (reg_write) begin
			case (reg_addr)
				`ADC_OFS_CSA: begin
					next_s.enable = reg_wdata[`CSA_EN];
					next_s.auto_trigger_enable = reg_wdata[`CSA_AUTO];
					next_s.conversion_done_irq_enable = reg_wdata[`CSA_IE];
					next_s.converter_clock_divider = reg_wdata[`CSA_DIV_HI:`CSA_DIV_LO];
					// writing zero to start does nothing
					start_req = reg_wdata[`CSA_START] & reg_wdata[`CSA_EN];
					// rewriting a set flag as one clears it
					clr_flag = reg_wdata[`CSA_FLAG];
				end
				`ADC_OFS_CHSEL: begin
					next_s.reference_select = reg_wdata[`CHSEL_REF_HI:`CHSEL_REF_LO];
					next_s.left_align_result = reg_wdata[`CHSEL_LEFT];
					next_s.input_channel_select =
						reg_wdata[`CHSEL_CHAN_HI:`CHSEL_CHAN_LO];
					if (s.fsm == adcctl_pkg::adcctl_idle) begin
						next_s.active_reference = next_s.reference_select;
						next_s.active_channel = next_s.input_channel_select;
					end
				end
				`ADC_OFS_TRIG: begin
					next_s.trigger_source_select = reg_wdata[`TRIG_SEL_HI:`TRIG_SEL_LO];
				end
				default: begin
				end
			endcase
		end

		// conversion sequencing in converter clocks
		last = s.initialized ? (`CONV_NORMAL_CLKS - 5'd1) : (`CONV_FIRST_CLKS - 5'd1);
		next_s.core_step = clk_if.tick;
		case (s.fsm)
			adcctl_pkg::adcctl_conv: begin
				if (clk_if.tick) begin
					if (s.count == last) begin
						fin = 1'b1;
					end else begin
						next_s.count = s.count + 5'd1;
					end
				end
			end
			adcctl_pkg::adcctl_idle: begin
				if (s.enable && s.auto_trigger_enable && trig_edge) begin
					start_req = 1'b1;
				end
			end
			default: begin
				next_s.fsm = adcctl_pkg::adcctl_idle;
			end
		endcase

		if (fin) begin
			next_s.fsm = adcctl_pkg::adcctl_idle;
			next_s.busy = 1'b0;
			next_s.initialized = 1'b1;
			next_s.count = 5'd0;
			// a pending low-byte read keeps the old result intact
			if (!s.locked) begin
				next_s.result = captured;
			end
			// held-off selections take effect now
			next_s.active_reference = next_s.reference_select;
			next_s.active_channel = next_s.input_channel_select;
			// free running restarts from completion, not from the flag level
			if (s.auto_trigger_enable && s.trigger_source_select == `TRIG_FREE) begin
				start_req = 1'b1;
			end
		end

		if (start_req && (next_s.fsm == adcctl_pkg::adcctl_idle)) begin
			next_s.fsm = adcctl_pkg::adcctl_conv;
			next_s.busy = 1'b1;
			next_s.count = 5'd0;
			next_s.core_start = 1'b1;
			next_s.active_reference = next_s.reference_select;
			next_s.active_channel = next_s.input_channel_select;
		end

		// turning off aborts and forces the long first conversion again
		if (!next_s.enable) begin
			next_s.fsm = adcctl_pkg::adcctl_idle;
			next_s.busy = 1'b0;
			next_s.initialized = 1'b0;
			next_s.count = 5'd0;
			next_s.core_start = 1'b0;
		end

		// completion wins over a clear in the same cycle
		next_s.conversion_done_flag = (s.conversion_done_flag &
			~(clr_flag | irq_vector_taken)) | fin;
		next_s.irq_request = next_s.conversion_done_flag &
			next_s.conversion_done_irq_enable & global_irq_enable;

		// register reads, data in the following cycle only
		if (reg_read) begin
			case (reg_addr)
				`ADC_OFS_CSA: begin
					next_s.rdata = {s.enable, s.busy, s.auto_trigger_enable,
						s.conversion_done_flag, s.conversion_done_irq_enable,
						s.converter_clock_divider};
				end
				`ADC_OFS_CHSEL: begin
					next_s.rdata = {s.reference_select, s.left_align_result,
						s.input_channel_select};
				end
				`ADC_OFS_TRIG: begin
					next_s.rdata = {5'h00, s.trigger_source_select};
				end
				`ADC_OFS_RES_LO: begin
					next_s.rdata = res_lo;
					next_s.locked = 1'b1;
				end
				`ADC_OFS_RES_HI: begin
					next_s.rdata = res_hi;
					next_s.locked = 1'b0;
				end
				default: begin
					next_s.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// every output straight from the state register
	assign reg_rdata = s.rdata;
	assign irq_request = s.irq_request;
	assign core_power = s.enable;
	assign core_start = s.core_start;
	assign core_step = s.core_step;
	assign core_reference = s.active_reference;
	assign core_channel = s.active_channel;

endmodule

`default_nettype wire

// ### testbench/adcctl_core_model.sv
// analog core stand-in: samples at start, answers late in the conversion
// assumes the bench sets the level and overrange it should report
`timescale 1ns/1ps
`default_nettype none
module adcctl_core_model (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// control
	input wire logic core_power,
	input wire logic core_start,
	input wire logic core_step,
	// bench level
	input wire logic [9:0] level,
	input wire logic over,
	// answer
	output logic [9:0] core_result,
	output logic core_overrange
);
	logic [9:0] held;
	logic held_over;
	logic [4:0] seen;
	logic ready;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			held <= 10'h000;
			held_over <= 1'b0;
			seen <= 5'h00;
		end else if (core_start) begin
			held <= level;
			held_over <= over;
			seen <= 5'h00;
		end else if (core_step && seen != 5'h1f) begin
			seen <= seen + 5'h01;
		end
	end
	// valid only by the final tick; inverted before so early capture shows
	assign ready = core_power && seen >= 5'd12;
	assign core_result = ready ? held : ~held;
	assign core_overrange = ready && held_over;
endmodule
`default_nettype wire

// ### testbench/adcctl_properties.sv
// checker on the converter control top ports
// assumes a bind from the bench; one clock domain
`timescale 1ns/1ps
`default_nettype none
module adcctl_properties (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	// interrupt side
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	input wire logic irq_request,
	// core side
	input wire logic core_power,
	input wire logic core_start,
	input wire logic core_step,
	input wire logic [1:0] core_reference,
	input wire logic [4:0] core_channel
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic [4:0] steps;
	sequence s_ctl_wr;
		reg_write && reg_addr == 8'h7a;
	endsequence
	sequence s_go;
		s_ctl_wr ##0 reg_wdata[7:6] == 2'b11;
	endsequence
	// steps seen since the last start; the final step lands with the flag
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			steps <= 5'h00;
		else
			steps <= core_start ? 5'h00 : steps + {4'h0, core_step};
	end
	a_first_start: assert property (!core_power ##0 s_go |=> core_start && core_power)
		else $error("start not issued");
	a_zero_no_start: assert property (s_ctl_wr ##0 !reg_wdata[6] |=> !core_start)
		else $error("zero start bit began a conversion");
	a_disable_stops: assert property (s_ctl_wr ##0 !reg_wdata[7] |=> !core_power && !core_start)
		else $error("core still powered");
	a_sel_held: assert property (core_start |=> ($stable(core_channel) && $stable(core_reference)) [*4])
		else $error("selection changed mid conversion");
	a_irq_gated: assert property (irq_request |-> $past(global_irq_enable))
		else $error("interrupt without global enable");
	a_vector_clears: assert property (irq_request && irq_vector_taken |=> !irq_request)
		else $error("vector did not clear flag");
	a_conv_length: assert property ($rose(irq_request) && core_step |-> (steps + {4'h0, core_step}) inside {5'd13, 5'd25})
		else $error("conversion length wrong");
	a_power_for_start: assert property (core_start |-> core_power)
		else $error("start while unpowered");
endmodule
`default_nettype wire

// ### testbench/test_adcctl_top.sv
// bench for the converter control top with a core model
// assumes 20 MHz mclk and the register offsets of the params header
`timescale 1ns/1ps
`default_nettype none
module test_adcctl_top;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic global_irq_enable = 1'b1;
	logic irq_vector_taken = 1'b0;
	logic [7:0] trigger_sources = 8'h00;
	logic [9:0] level = 10'h000;
	logic over = 1'b0;
	logic [7:0] reg_rdata;
	logic irq_request, core_power, core_start, core_step, core_overrange;
	logic [1:0] core_reference;
	logic [4:0] core_channel;
	logic [9:0] core_result;
	int n_errors = 0;
	int tests_run = 0;
	int n_starts = 0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) if (core_start === 1'b1) n_starts++;
	adcctl_top adcctl_top_i (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .global_irq_enable, .irq_vector_taken, .irq_request,
		.trigger_sources, .core_power, .core_start, .core_step, .core_reference,
		.core_channel, .core_result, .core_overrange);
	adcctl_core_model adcctl_core_model_i (.mclk, .reset_n, .core_power, .core_start,
		.core_step, .level, .over, .core_result, .core_overrange);
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 chk(what, reg_rdata, exp);
	endtask
	// bounded wait for the interrupt (0) or a converter step (1)
	task automatic wait_for(input logic step);
		for (int i = 0; i < 4000; i++) begin
			@(posedge mclk);
			#1;
			if (step ? core_step === 1'b1 : irq_request === 1'b1) return;
		end
		n_errors++;
		$display("[ERR] wait timed out");
		summarize();
	endtask
	task automatic t_single;
		wr(8'h70, 8'hff);
		rd(8'h70, 8'h00, "unmapped");
		rd(8'h7a, 8'h00, "ctl reset");
		level <= 10'h2a5;
		wr(8'h7c, 8'h03);
		wr(8'h7a, 8'hc8);
		wr(8'h7c, 8'he5);
		#1 chk("chan held", {3'h0, core_channel}, 8'h03);
		rd(8'h7a, 8'hc8, "busy");
		wait_for(1'b0);
		chk("chan", {3'h0, core_channel}, 8'h05);
		chk("ref", {6'h00, core_reference}, 8'h03);
		rd(8'h78, 8'h40, "left lo");
		rd(8'h79, 8'ha9, "left hi");
		wr(8'h7c, 8'h05);
		rd(8'h78, 8'ha5, "right lo");
		rd(8'h79, 8'h02, "right hi");
		rd(8'h7a, 8'h98, "flag");
		wr(8'h7a, 8'h98);
		rd(8'h7a, 8'h88, "flag clr");
		$display("single done");
	endtask
	task automatic t_diff;
		level <= 10'h3a3;
		wr(8'h7c, 8'hfb);
		wr(8'h7a, 8'hc8);
		wait_for(1'b0);
		rd(8'h78, 8'hc0, "diff lo");
		level <= 10'h155;
		wr(8'h7a, 8'hd8);
		wait_for(1'b0);
		rd(8'h79, 8'he8, "frozen hi");
		rd(8'h78, 8'hc0, "kept lo");
		rd(8'h79, 8'he8, "kept hi");
		over <= 1'b1;
		wr(8'h7a, 8'hd8);
		wait_for(1'b0);
		over <= 1'b0;
		rd(8'h78, 8'hc0, "sat lo");
		rd(8'h79, 8'h7f, "sat hi");
		$display("diff done");
	endtask
	task automatic t_irq;
		wr(8'h7a, 8'h08);
		global_irq_enable <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 chk("irq masked", {7'h00, irq_request}, 8'h00);
		@(posedge mclk);
		global_irq_enable <= 1'b1;
		repeat (2) @(posedge mclk);
		#1 chk("irq up", {7'h00, irq_request}, 8'h01);
		@(posedge mclk);
		irq_vector_taken <= 1'b1;
		@(posedge mclk);
		irq_vector_taken <= 1'b0;
		#1 chk("irq taken", {7'h00, irq_request}, 8'h00);
		rd(8'h7a, 8'h08, "vector clr");
		$display("irq done");
	endtask
	task automatic t_abort;
		wr(8'h7a, 8'hc8);
		repeat (20) @(posedge mclk);
		wr(8'h7a, 8'h08);
		repeat (80) @(posedge mclk);
		#1 chk("no done", {7'h00, irq_request}, 8'h00);
		rd(8'h7a, 8'h08, "aborted");
		wr(8'h7a, 8'hc8);
		wait_for(1'b0);
		wr(8'h7a, 8'h18);
		$display("abort done");
	endtask
	// the bandgap code ignores the overrange answer; the last pair code does not
	task automatic t_codes;
		level <= 10'h3ff;
		over <= 1'b1;
		wr(8'h7c, 8'h1e);
		wr(8'h7a, 8'hd8);
		wait_for(1'b0);
		chk("bandgap chan", {3'h0, core_channel}, 8'h1e);
		rd(8'h78, 8'hff, "bandgap lo");
		rd(8'h79, 8'h03, "bandgap hi");
		wr(8'h7c, 8'h1d);
		wr(8'h7a, 8'hd8);
		wait_for(1'b0);
		rd(8'h78, 8'hff, "pair lo");
		rd(8'h79, 8'h01, "pair hi");
		over <= 1'b0;
		wr(8'h7a, 8'h18);
		$display("codes done");
	endtask
	task automatic t_auto;
		int base;
		base = n_starts;
		wr(8'h7b, 8'h02);
		wr(8'h7a, 8'ha8);
		trigger_sources <= 8'h04;
		wait_for(1'b0);
		chk("trig start", 8'(n_starts - base), 8'h01);
		trigger_sources <= 8'h00;
		wr(8'h7b, 8'h00);
		repeat (100) @(posedge mclk);
		chk("free no trig", 8'(n_starts - base), 8'h01);
		wr(8'h7a, 8'h10);
		$display("auto done");
	endtask
	task automatic t_div;
		int c;
		for (int k = 0; k < 8; k++) begin
			wr(8'h7a, {5'h18, k[2:0]});
			wait_for(1'b1);
			c = 0;
			do begin
				@(posedge mclk);
				c++;
				#1;
			end while (core_step !== 1'b1 && c < 300);
			chk("div", 8'(c), 8'(1 << (k < 2 ? 1 : k)));
			wr(8'h7a, 8'h00);
		end
		$display("div done");
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		t_single;
		t_diff;
		t_irq;
		t_abort;
		t_codes;
		t_auto;
		t_div;
		summarize();
	end
endmodule
bind adcctl_top adcctl_properties adcctl_properties_i (.mclk, .reset_n, .reg_addr,
	.reg_wdata, .reg_write, .global_irq_enable, .irq_vector_taken, .irq_request,
	.core_power, .core_start, .core_step, .core_reference, .core_channel);
`default_nettype wire
